// [verilog/smc_pkg.sv]
// constants shared by the standby mode control block
package smc_pkg;

    // ---------------------------------------------------------------
    // register map (byte addresses on the wishbone bus)
    // ---------------------------------------------------------------
    localparam logic [3:0] SMC_ADR_SYS1   = 4'h0;
    localparam logic [3:0] SMC_ADR_SYS2   = 4'h4;
    localparam logic [3:0] SMC_ADR_CTRL   = 4'h8;
    localparam logic [3:0] SMC_ADR_STATUS = 4'hC;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int SYS1_HALT_BIT   = 7;
    localparam int SYS1_STYLE_BIT  = 6;
    localparam int SYS1_RETSUB_BIT = 5;
    localparam int SYS1_FIX_BIT    = 4;
    localparam int SYS1_WU_LSB     = 2;
    localparam int SYS2_HOSC_BIT   = 7;
    localparam int SYS2_LOSC_BIT   = 6;
    localparam int SYS2_SYSCK_BIT  = 5;
    localparam int SYS2_DOZE_BIT   = 4;
    localparam int CTRL_IME_BIT    = 0;
    localparam int CTRL_GEAR_BIT   = 1;
    localparam int CTRL_EF_LSB     = 8;
    localparam int SMC_NSRC        = 8;

    // ---------------------------------------------------------------
    // values after reset
    // ---------------------------------------------------------------
    localparam logic [7:0] SYS1_RESET  = 8'h10;
    localparam logic [7:0] SYS2_RESET  = 8'h80;
    localparam logic [7:0] SYS2_LOW_RD = 8'h0F;
    localparam logic [7:0] EF_RESET    = 8'h00;

    // ---------------------------------------------------------------
    // warm-up times and their cycle counts
    // ---------------------------------------------------------------
    localparam longint CLK_MHZ   = 125;
    localparam longint WU0_US    = 15729;
    localparam longint WU1_US    = 5243;
    localparam longint WU2_US    = 3932;
    localparam longint WU3_US    = 1311;
    localparam longint WUS0_MS   = 750;
    localparam longint WUS1_MS   = 250;
    localparam logic [31:0] WU0_CYC  = 32'(WU0_US * CLK_MHZ);
    localparam logic [31:0] WU1_CYC  = 32'(WU1_US * CLK_MHZ);
    localparam logic [31:0] WU2_CYC  = 32'(WU2_US * CLK_MHZ);
    localparam logic [31:0] WU3_CYC  = 32'(WU3_US * CLK_MHZ);
    localparam logic [31:0] WUS0_CYC = 32'(WUS0_MS * 1000 * CLK_MHZ);
    localparam logic [31:0] WUS1_CYC = 32'(WUS1_MS * 1000 * CLK_MHZ);

    // ---------------------------------------------------------------
    // operating states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        SMC_RUN,
        SMC_HALT,
        SMC_WARM,
        SMC_DOZE
    } smc_state_t;

endpackage

// [verilog/smc_standby.sv]
// standby mode control: halt, warm-up and doze sequencing with a wishbone slave
// What this block does
// RL1 - writing halt bit seven enters halt
// RL2 - halt stops oscillators and all operation
// RL3 - halt keeps memory, registers, latches intact
// RL4 - divider cleared at halt entry and resume
// RL5 - resume address is the following instruction
// RL6 - bit six picks level or edge release
// RL7 - level style: high wake pin releases halt
// RL8 - level style: pin high skips halt, warms
// RL9 - warm-up never falls back into halt
// RL10 - edge-to-level switch waits for rising edge
// RL11 - edge style: rising wake edge releases halt
// RL12 - edge style: halts even with pin high
// RL13 - oscillators restarted according to target mode
// RL14 - warm-up keeps everything halted, then resumes
// RL15 - two-bit field selects four warm-up lengths, two on sub-clock return
// RL16 - warm-up counted through the timing divider
// RL17 - reset releases halt immediately
// RL18 - writing doze bit four enters doze
// RL19 - doze stops cpu and watchdog only
// RL20 - doze returns to matching run mode
// RL21 - master enable low: release without service
// RL22 - master enable high: release and service
// RL23 - reset releases doze into fast single
// RL24 - watchdog interrupt at entry cancels doze
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module smc_standby
    import smc_pkg::*;
#(
    parameter logic [31:0] WARM0_CYC    = WU0_CYC,
    parameter logic [31:0] WARM1_CYC    = WU1_CYC,
    parameter logic [31:0] WARM2_CYC    = WU2_CYC,
    parameter logic [31:0] WARM3_CYC    = WU3_CYC,
    parameter logic [31:0] WARM_SUB0_CYC = WUS0_CYC,
    parameter logic [31:0] WARM_SUB1_CYC = WUS1_CYC
) (
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // wishbone slave
    input  wire logic                cyc_i,
    input  wire logic                stb_i,
    input  wire logic                we_i,
    input  wire logic [3:0]          adr_i,
    input  wire logic [3:0]          sel_i,
    input  wire logic [31:0]         dat_i,
    output logic [31:0]              dat_o,
    output logic                     ack_o,
    // wake pin and interrupt sources
    input  wire logic                wake_pin_i,
    input  wire logic [SMC_NSRC-1:0] interrupt_latch_i,
    input  wire logic                external_interrupt_zero_i,
    input  wire logic                watchdog_irq_i,
    // cpu side
    input  wire logic [15:0]         cpu_pc_i,
    output logic [15:0]              resume_pc_o,
    output logic                     cpu_run_o,
    output logic                     watchdog_run_o,
    output logic                     periph_run_o,
    output logic                     service_start_o,
    output logic                     resume_o,
    // clock control
    output logic                     hosc_en_o,
    output logic                     losc_en_o,
    output logic                     sysck_sub_o,
    output logic [31:0]              divider_o
);

    // ---------------------------------------------------------------
    // wake pin synchroniser
    // ---------------------------------------------------------------
    // no reset here: the flops fill from the pin within three edges, well
    // inside the shortest reset, and a reset value could fake an edge
    logic wake_meta;
    logic wake_sync;
    logic wake_prev;
    always_ff @(posedge clk_i) begin
        wake_meta <= wake_pin_i;
        wake_sync <= wake_meta;
        wake_prev <= wake_sync;
    end
    wire wake_rise = wake_sync & ~wake_prev;

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0]          sys1;
    logic [7:0]          sys2;
    logic                ime;
    logic                gear;
    logic [SMC_NSRC-1:0] src_en;
    logic                eff_level;
    logic                lvl_pend;
    smc_state_t          state;
    smc_state_t          next_state;
    logic [31:0]         tg_div;
    logic [31:0]         warm_target;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    wire acc      = cyc_i & stb_i & ~ack_o;
    wire wr       = acc & we_i & sel_i[0];
    wire wr_sys1  = wr & (adr_i == SMC_ADR_SYS1);
    wire wr_sys2  = wr & (adr_i == SMC_ADR_SYS2);
    wire wr_ctrl  = wr & (adr_i == SMC_ADR_CTRL);
    wire in_run   = (state == SMC_RUN);
    // a style change from edge to level is held off until a rising edge
    wire to_level = wr_sys1 & dat_i[SYS1_STYLE_BIT] & ~eff_level;
    wire to_edge  = wr_sys1 & ~dat_i[SYS1_STYLE_BIT];
    wire next_eff = to_edge ? 1'b0 : (eff_level | (lvl_pend & wake_rise)); // RL6 RL10
    wire halt_req = in_run & wr_sys1 & dat_i[SYS1_HALT_BIT];                 // RL1
    wire doze_req = in_run & wr_sys2 & dat_i[SYS2_DOZE_BIT];                 // RL18
    wire doze_cancel = doze_req & watchdog_irq_i;                            // RL24
    wire [SMC_NSRC-1:0] src_hit = interrupt_latch_i & src_en;
    wire doze_wake = (|src_hit) | external_interrupt_zero_i;                 // RL21 RL22
    wire [1:0] wu_sel = sys1[SYS1_WU_LSB +: 2];
    wire ret_sub = sys1[SYS1_RETSUB_BIT];
    wire dual    = sys2[SYS2_LOSC_BIT];
    // one below the target, so warm-up spans exactly the target count from clear
    wire warm_done = (state == SMC_WARM) && (tg_div >= warm_target - 32'h1);
    wire halt_wake = eff_level ? wake_sync : wake_rise;                      // RL7 RL11

    wire [31:0] rd_sys1   = {24'h0, 1'b0, sys1[6:2], 2'b00};
    wire [31:0] rd_sys2   = {24'h0, sys2[7:4], SYS2_LOW_RD[3:0]};
    wire [31:0] rd_ctrl   = {16'h0, src_en, 6'h00, gear, ime};
    wire [31:0] rd_status = {24'h0, wake_sync, lvl_pend, eff_level, 3'b000, state};
    wire [31:0] rd_mux =
        (adr_i == SMC_ADR_SYS1)   ? rd_sys1 :
        (adr_i == SMC_ADR_SYS2)   ? rd_sys2 :
        (adr_i == SMC_ADR_CTRL)   ? rd_ctrl :
        (adr_i == SMC_ADR_STATUS) ? rd_status : 32'h0;

    // ---------------------------------------------------------------
    // warm-up length select
    // ---------------------------------------------------------------
    // sub-clock return only defines the two slowest codes; the others
    // reuse them by the low bit, code 2 as code 0 and code 3 as code 1, rather than an undefined length
    always_comb begin
        warm_target = WARM0_CYC;
        if (ret_sub) begin
            warm_target = wu_sel[0] ? WARM_SUB1_CYC : WARM_SUB0_CYC;   // RL15
        end else begin
            unique case (wu_sel)
                2'b00: warm_target = WARM0_CYC;
                2'b01: warm_target = WARM1_CYC;
                2'b10: warm_target = WARM2_CYC;
                2'b11: warm_target = WARM3_CYC;
            endcase
            if (gear) begin
                warm_target = {warm_target[30:0], 1'b0};                 // RL15
            end
        end
    end

    // ---------------------------------------------------------------
    // state machine
    // ---------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            SMC_RUN: begin
                if (halt_req) begin
                    // level style with the pin already high goes straight to warm-up
                    next_state = (next_eff & wake_sync) ? SMC_WARM : SMC_HALT; // RL8 RL12
                end else if (doze_req & ~doze_cancel) begin
                    next_state = SMC_DOZE;
                end
            end
            SMC_HALT: begin
                if (halt_wake) begin
                    next_state = SMC_WARM;
                end
            end
            SMC_WARM: begin
                if (warm_done) begin
                    next_state = SMC_RUN;                                // RL9 RL14
                end
            end
            SMC_DOZE: begin
                if (doze_wake) begin
                    next_state = SMC_RUN;                                // RL20
                end
            end
        endcase
    end

    // reset is the pin-driven release of every standby state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= SMC_RUN;                                            // RL17 RL23
        end else begin
            state <= next_state;
        end
    end

    // ---------------------------------------------------------------
    // timing divider, doubles as the warm-up counter
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tg_div <= 32'h0;
        end else if (halt_req || warm_done) begin
            tg_div <= 32'h0;                                             // RL4
        end else if (state != SMC_HALT) begin
            tg_div <= tg_div + 32'h1;                                    // RL16
        end
    end

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys1      <= SYS1_RESET;
            sys2      <= SYS2_RESET;
            ime       <= 1'b0;
            gear      <= 1'b0;
            src_en    <= EF_RESET;
            eff_level <= 1'b0;
            lvl_pend  <= 1'b0;
        end else begin
            eff_level <= next_eff;
            if (to_edge || next_eff) begin
                lvl_pend <= 1'b0;
            end else if (to_level) begin
                lvl_pend <= 1'b1;
            end
            if (wr_sys1) begin
                sys1 <= {1'b0, dat_i[6:2], 2'b00};
            end
            if (wr_sys2) begin
                sys2 <= {dat_i[7:5], 1'b0, 4'h0};
            end
            if (wr_ctrl) begin
                ime  <= dat_i[CTRL_IME_BIT];
                gear <= dat_i[CTRL_GEAR_BIT];
            end
            if (wr_ctrl && sel_i[1]) begin
                src_en <= dat_i[CTRL_EF_LSB +: SMC_NSRC];
            end
            // oscillator and clock select follow the return target
            if (warm_done) begin
                sys2[SYS2_HOSC_BIT]  <= ~ret_sub;                        // RL13
                sys2[SYS2_SYSCK_BIT] <= ret_sub;
            end
        end
    end

    // ---------------------------------------------------------------
    // bus answer: one wait state, unmapped reads return zero
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= acc;
            dat_o <= acc ? rd_mux : 32'h0;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    wire warm_hosc = ret_sub ? 1'b0 : 1'b1;
    wire warm_losc = dual;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_run_o       <= 1'b1;
            watchdog_run_o  <= 1'b1;
            periph_run_o    <= 1'b1;
            service_start_o <= 1'b0;
            resume_o        <= 1'b0;
            hosc_en_o       <= 1'b1;
            losc_en_o       <= 1'b0;
            sysck_sub_o     <= 1'b0;
            resume_pc_o     <= 16'h0;
            divider_o       <= 32'h0;
        end else begin
            // cpu state is never touched here, only its clock is gated
            cpu_run_o      <= (next_state == SMC_RUN);                   // RL3 RL19
            watchdog_run_o <= (next_state == SMC_RUN);                   // RL19
            periph_run_o   <= (next_state == SMC_RUN) || (next_state == SMC_DOZE); // RL2 RL14
            service_start_o <= ((state == SMC_DOZE) && doze_wake && ime)
                               || doze_cancel;                           // RL22 RL24
            resume_o       <= (state != SMC_RUN) && (next_state == SMC_RUN);
            if (halt_req || doze_req) begin
                resume_pc_o <= cpu_pc_i + 16'h1;                         // RL5
            end
            unique case (next_state)
                SMC_HALT: begin
                    hosc_en_o <= 1'b0;                                   // RL2
                    losc_en_o <= 1'b0;
                end
                SMC_WARM: begin
                    hosc_en_o <= warm_hosc;                              // RL13
                    losc_en_o <= warm_losc;
                end
                default: begin
                    // the return bit overwrites the enable in the resume cycle
                    // itself; the stored bit would lag it by one cycle
                    hosc_en_o <= warm_done ? ~ret_sub : sys2[SYS2_HOSC_BIT];     // RL13
                    losc_en_o <= dual;
                end
            endcase
            sysck_sub_o <= warm_done ? ret_sub : sys2[SYS2_SYSCK_BIT];
            divider_o   <= tg_div;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking smc_cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_halt_cmd;
        halt_req && !(next_eff && wake_sync);
    endsequence
    sequence s_in_halt;
        state == SMC_HALT;
    endsequence

    AST_HALT_ENTRY: assert property (s_halt_cmd |=> s_in_halt) // RL1
        else $error("halt request did not enter halt");
    AST_HALT_OSC_OFF: assert property (s_in_halt |-> !hosc_en_o && !losc_en_o
        && !cpu_run_o && !periph_run_o) // RL2
        else $error("activity seen during halt");
    AST_DIV_CLEAR: assert property (halt_req |=> tg_div == 32'h0) // RL4
        else $error("divider not cleared on halt entry");
    AST_RESUME_PC: assert property ((halt_req || doze_req) |=>
        resume_pc_o == $past(cpu_pc_i) + 16'h1) // RL5
        else $error("resume address wrong");
    AST_LEVEL_SKIP: assert property (halt_req && next_eff && wake_sync |=>
        state == SMC_WARM) // RL8
        else $error("level style halted with pin high");
    AST_LEVEL_WAKE: assert property (s_in_halt ##0 (eff_level && wake_sync) |=>
        state == SMC_WARM) // RL7
        else $error("level release missed");
    AST_EDGE_WAKE: assert property (s_in_halt ##0 (!eff_level && wake_rise) |=>
        state == SMC_WARM) // RL11
        else $error("edge release missed");
    AST_EDGE_PIN_HIGH: assert property (halt_req && !next_eff && wake_sync |=>
        s_in_halt) // RL12
        else $error("edge style failed to halt with pin high");
    AST_NO_REHALT: assert property (state == SMC_WARM |=>
        state inside {SMC_WARM, SMC_RUN}) // RL9
        else $error("warm-up fell back to halt");
    AST_WARM_END: assert property (warm_done |=> state == SMC_RUN
        && tg_div == 32'h0 ##1 cpu_run_o) // RL14
        else $error("warm-up end mishandled");
    AST_DOZE_RUN: assert property (state == SMC_DOZE && !$past(state != SMC_DOZE)
        |-> periph_run_o && !cpu_run_o && !watchdog_run_o) // RL19
        else $error("doze gating wrong");
    AST_DOZE_SERVICE: assert property (state == SMC_DOZE && doze_wake |=>
        state == SMC_RUN && service_start_o == ime) // RL21 RL22
        else $error("doze release mishandled");
    AST_WDT_CANCEL: assert property (doze_cancel |=> state == SMC_RUN
        && service_start_o) // RL24
        else $error("doze entered despite watchdog interrupt");
    AST_DOZE_ENTRY: assert property (doze_req && !doze_cancel |=>
        state == SMC_DOZE) // RL18
        else $error("doze request ignored");

endmodule
`default_nettype wire

// [tb/smc_wake_model.sv]
// wake pin source and reset circuit that sit outside the standby block
`timescale 1ns/1ns
`default_nettype none
module smc_wake_model (
    // clock
    input  wire logic clk_i,
    // commands from the bench
    input  wire logic wake_level_i,
    input  wire logic reset_req_i,
    // towards the block
    output logic      wake_pin_o,
    output logic      rst_o
);
    logic [4:0] pwr_cnt;
    initial pwr_cnt = 5'h00;
    initial wake_pin_o = 1'b0;
    // the pin moves one edge after the request, on the same rising edge that the synchroniser samples
    always @(posedge clk_i) begin
        wake_pin_o <= wake_level_i;
        if (pwr_cnt != 5'h10) begin
            pwr_cnt <= pwr_cnt + 5'h01;
        end
    end
    // power-on reset spans 16 edges, later resets come on request
    assign rst_o = (pwr_cnt != 5'h10) || reset_req_i;
endmodule
`default_nettype wire

// [tb/standby_mode_control_test.sv]
// self-checking bench for the standby mode control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; $display("mismatch at %0t: got %0h expected %0h", $time, (a), (e)); end end
module standby_mode_control_test
    import smc_pkg::*;
;
    // ---------------------------------------------------------------
    // stimulus and observed signals
    // ---------------------------------------------------------------
    logic        clk_i = 1'b0;
    logic        rst_i, wake_pin, ack_o, resume_o, service_start_o;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, external_interrupt_zero = 1'b0, wdog = 1'b0;
    logic        wake_req = 1'b0, reset_req = 1'b0;
    logic        cpu_run_o, watchdog_run_o, periph_run_o, hosc_en_o, losc_en_o, sysck_sub_o;
    logic [3:0]  adr = 4'h0, sel = 4'hF;
    logic [7:0]  latch = 8'h00;
    logic [15:0] pc = 16'h1234;
    logic [15:0] resume_pc_o;
    logic [31:0] wdat = 32'h0, dat_o, divider_o, rd;
    int          err_count = 0, compares = 0, svc_cnt = 0, s0;
    // short warm-up lengths so every code fits in the run
    localparam logic [31:0] WT0 = 32'h28, WT1 = 32'h1E, WT2 = 32'h14, WT3 = 32'h0A;
    localparam logic [31:0] WTS0 = 32'h3C, WTS1 = 32'h32;
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) if (service_start_o === 1'b1) svc_cnt++;
    smc_wake_model i_smc_wake_model (.clk_i(clk_i), .wake_level_i(wake_req),
        .reset_req_i(reset_req), .wake_pin_o(wake_pin), .rst_o(rst_i));
    smc_standby #(.WARM0_CYC(WT0), .WARM1_CYC(WT1), .WARM2_CYC(WT2),
        .WARM3_CYC(WT3), .WARM_SUB0_CYC(WTS0), .WARM_SUB1_CYC(WTS1)) i_smc_standby (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .wake_pin_i(wake_pin),
        .interrupt_latch_i(latch), .external_interrupt_zero_i(external_interrupt_zero),
        .watchdog_irq_i(wdog), .cpu_pc_i(pc), .resume_pc_o(resume_pc_o),
        .cpu_run_o(cpu_run_o), .watchdog_run_o(watchdog_run_o), .periph_run_o(periph_run_o),
        .service_start_o(service_start_o), .resume_o(resume_o), .hosc_en_o(hosc_en_o),
        .losc_en_o(losc_en_o), .sysck_sub_o(sysck_sub_o), .divider_o(divider_o));
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic tally_and_finish();
        $display("counts: %0d compares, %0d mismatches", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // one classic wishbone cycle; the answer is taken at the ack edge only
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 20) begin
            err_count++;
            tally_and_finish();
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask
    task automatic pin(input logic v);
        @(posedge clk_i);
        wake_req <= v;
    endtask
    task automatic pulse_reset();
        @(posedge clk_i);
        reset_req <= 1'b1;
        tick(2);
        @(posedge clk_i);
        reset_req <= 1'b0;
        tick(2);
    endtask
    // counts cycles to the resume pulse; the window allows for pin sync
    task automatic wait_resume(input int lo, input int hi);
        int k;
        k = 0;
        while (resume_o !== 1'b1 && k < 400) begin
            @(posedge clk_i);
            #1;
            k++;
        end
        `CHK(k >= lo && k <= hi, 1'b1)
        if (k >= 400) tally_and_finish();
    endtask
    // edge style halt with the pin already high, then a rising edge
    task automatic halt_case(input logic [1:0] wu, input logic gear, input logic ret,
                             input int t, input logic [1:0] osc);
        wb(1'b1, SMC_ADR_CTRL, {30'h0, gear, 1'b0});
        pin(1'b1);
        pc <= pc + 16'h0100;
        // let a rising edge from before entry pass the synchroniser first
        tick(4);
        wb(1'b1, SMC_ADR_SYS1, {24'h0, 1'b1, 1'b0, ret, 1'b1, wu, 2'b00});
        tick(6);
        `CHK(cpu_run_o, 1'b0)
        `CHK({hosc_en_o, losc_en_o}, 2'b00)
        `CHK(divider_o, 32'h0)
        pin(1'b0);
        tick(4);
        pin(1'b1);
        wait_resume(t, t + 10);
        `CHK({cpu_run_o, resume_pc_o}, {1'b1, pc + 16'h0001})
        `CHK({hosc_en_o, losc_en_o, sysck_sub_o}, {osc, ret})
        $display("test halt code %0d gear %0d sub %0d done", wu, gear, ret);
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        tick(20);
        wb(1'b0, SMC_ADR_SYS1, 32'h0);
        `CHK(rd[7:0], SYS1_RESET)
        wb(1'b0, SMC_ADR_SYS2, 32'h0);
        `CHK(rd[7:0], SYS2_RESET | SYS2_LOW_RD)
        wb(1'b0, 4'h2, 32'h0);
        `CHK(rd, 32'h0)
        `CHK({cpu_run_o, hosc_en_o, losc_en_o}, 3'b110)
        $display("test reset values done");
        halt_case(2'd0, 1'b0, 1'b0, WT0, 2'b10);
        halt_case(2'd1, 1'b0, 1'b0, WT1, 2'b10);
        halt_case(2'd2, 1'b0, 1'b0, WT2, 2'b10);
        halt_case(2'd3, 1'b0, 1'b0, WT3, 2'b10);
        halt_case(2'd3, 1'b1, 1'b0, 2 * WT3, 2'b10);
        wb(1'b1, SMC_ADR_SYS2, 32'hC0);
        halt_case(2'd0, 1'b0, 1'b0, WT0, 2'b11);
        halt_case(2'd0, 1'b0, 1'b1, WTS0, 2'b01);
        halt_case(2'd1, 1'b0, 1'b1, WTS1, 2'b01);
        wb(1'b1, SMC_ADR_SYS1, 32'h90);
        pin(1'b0);
        tick(4);
        pulse_reset();
        `CHK({cpu_run_o, hosc_en_o, losc_en_o, sysck_sub_o}, 4'b1100)
        $display("test reset in halt done");
        wb(1'b1, SMC_ADR_SYS1, 32'h5C);
        wb(1'b0, SMC_ADR_STATUS, 32'h0);
        `CHK(rd[6:5], 2'b10)
        pin(1'b1);
        tick(6);
        wb(1'b0, SMC_ADR_STATUS, 32'h0);
        `CHK(rd[7:5], 3'b101)
        wb(1'b1, SMC_ADR_SYS1, 32'hDC);
        wb(1'b0, SMC_ADR_STATUS, 32'h0);
        `CHK(rd[1:0], 2'd2)
        pin(1'b0);
        wait_resume(1, 12);
        wb(1'b1, SMC_ADR_SYS1, 32'hD0);
        tick(4);
        wb(1'b0, SMC_ADR_STATUS, 32'h0);
        `CHK(rd[1:0], 2'd1)
        pin(1'b1);
        wait_resume(WT0, WT0 + 10);
        $display("test level release done");
        wb(1'b1, SMC_ADR_CTRL, 32'h0100);
        @(posedge clk_i);
        sel <= 4'h1;
        wb(1'b1, SMC_ADR_CTRL, 32'h0);
        wb(1'b0, SMC_ADR_CTRL, 32'h0);
        `CHK(rd[15:0], 16'h0100)
        @(posedge clk_i);
        sel <= 4'hF;
        wb(1'b1, SMC_ADR_SYS2, 32'hD0);
        tick(2);
        `CHK({cpu_run_o, watchdog_run_o, periph_run_o}, 3'b001)
        s0 = svc_cnt;
        @(posedge clk_i);
        latch <= 8'h02;
        tick(8);
        `CHK(cpu_run_o, 1'b0)
        @(posedge clk_i);
        latch <= 8'h03;
        wait_resume(1, 6);
        `CHK({svc_cnt == s0, losc_en_o, sysck_sub_o}, 3'b110)
        @(posedge clk_i);
        latch <= 8'h00;
        wb(1'b1, SMC_ADR_CTRL, 32'h0101);
        wb(1'b1, SMC_ADR_SYS2, 32'hD0);
        tick(2);
        @(posedge clk_i);
        external_interrupt_zero <= 1'b1;
        wait_resume(1, 6);
        tick(2);
        `CHK(svc_cnt - s0, 1)
        @(posedge clk_i);
        external_interrupt_zero <= 1'b0;
        wdog <= 1'b1;
        wb(1'b1, SMC_ADR_SYS2, 32'hD0);
        tick(2);
        `CHK({cpu_run_o, svc_cnt - s0 == 2}, 2'b11)
        @(posedge clk_i);
        wdog <= 1'b0;
        wb(1'b1, SMC_ADR_SYS2, 32'hD0);
        tick(2);
        `CHK(cpu_run_o, 1'b0)
        pulse_reset();
        `CHK({cpu_run_o, hosc_en_o, losc_en_o, sysck_sub_o}, 4'b1100)
        $display("test doze done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
